// ==== shared/sms_consts.svh ====
// constants of the startup mode and port select block
// assumes a 32-bit classic wishbone register bus, byte addressed
// How it works
// R01: switch two off: peripheral port is terminal; on: stored or standard settings.
// R02: switch one off: serial port uses stored words; on: standard settings.
// R03: selector byte 00 switches, 01 last mode, 02 lower byte mode.
// R04: selector 00 and switch two on: run mode at once.
// R05: selector 00, switch two off, terminal attached: terminal key switch decides.
// R06: switch setting and attached device disagree: program mode, no communication. The code forces program mode only with selector 00.
// R07: startup selector byte resets to 00.
// R08: newer units detect an attached terminal themselves, not by switch.
// R09: nothing attached: switch two off gives program, on gives run.
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH
// register byte offsets
`define SMS_OFF_SETTING 4'h0
`define SMS_OFF_CTRL 4'h4
`define SMS_OFF_STATUS 4'h8
// setting word fields and reset
`define SMS_SEL_HI 15
`define SMS_SEL_LO 8
`define SMS_SETTING_RST 16'h0000
// selector codes
`define SMS_SEL_SWITCH 8'h00
`define SMS_SEL_LAST 8'h01
`define SMS_SEL_WORD 8'h02
// lower byte mode codes
`define SMS_LOW_PROG 8'h00
`define SMS_LOW_MON 8'h01
`define SMS_LOW_RUN 8'h02
// control bits
`define SMS_CTRL_START 0
`define SMS_CTRL_AUTO 1
`define SMS_AUTO_RST 1'b1
`endif

// ==== shared/sms_pkg.sv ====
// types of the startup mode and port select block
// assumes nothing beyond the tool's package support
package sms_pkg;
  // operating modes
  typedef enum logic [1:0] {
    SMS_MODE_PROG = 2'h0,
    SMS_MODE_MON = 2'h1,
    SMS_MODE_RUN = 2'h2
  } sms_mode_t;
  // device seen on the peripheral port
  typedef enum logic [1:0] {
    SMS_DEV_NONE = 2'h0,
    SMS_DEV_TERM = 2'h1,
    SMS_DEV_OTHER = 2'h2
  } sms_dev_t;
  // peripheral port configuration
  typedef enum logic [1:0] {
    SMS_PCFG_TERM = 2'h0,
    SMS_PCFG_STORED = 2'h1,
    SMS_PCFG_STD = 2'h2
  } sms_pcfg_t;
  // sequencer states, one-hot
  typedef enum logic [2:0] {
    SMS_ST_IDLE = 3'b001,
    SMS_ST_LATCH = 3'b010,
    SMS_ST_DONE = 3'b100
  } sms_state_t;
endpackage

// ==== shared/sms_if.sv ====
// decision inputs and results between top and decision logic
// assumes both ends sit in the same clock domain
`timescale 1ns/1ps
interface sms_if;
  import sms_pkg::*;
  logic [15:0] setting;
  logic port_sw;
  logic periph_sw;
  logic auto_en;
  sms_dev_t dev;
  sms_mode_t key_mode;
  sms_mode_t last_mode;
  sms_mode_t mode;
  sms_pcfg_t pcfg;
  logic ser_std;
  logic mismatch;
  // top supplies inputs, takes results
  modport top (
    output setting, port_sw, periph_sw, auto_en, dev, key_mode, last_mode,
    input mode, pcfg, ser_std, mismatch
  );
  // decision logic takes inputs, gives results
  modport dec (
    input setting, port_sw, periph_sw, auto_en, dev, key_mode, last_mode,
    output mode, pcfg, ser_std, mismatch
  );
endinterface

// ==== rtl/sms_decide.sv ====
// combinational startup mode and port configuration decision
// assumes inputs are stable while the top samples the results
`timescale 1ns/1ps
`include "sms_consts.svh"
module sms_decide
  import sms_pkg::*;
(
  // decision inputs and results
  sms_if.dec d
);
  logic [7:0] sel;
  logic [7:0] low;
  sms_dev_t eff_dev;
  assign sel = d.setting[`SMS_SEL_HI:`SMS_SEL_LO];
  assign low = d.setting[7:0];
  // without detection the switch is taken as the truth
  assign eff_dev = d.auto_en ? d.dev :                  // R08
    (d.periph_sw ? SMS_DEV_OTHER : SMS_DEV_TERM);
  // port configuration follows the two switches
  always_comb begin
    d.ser_std = d.port_sw;                              // R02
    if (!d.periph_sw) begin
      d.pcfg = SMS_PCFG_TERM;                           // R01
    end else if (d.port_sw) begin
      d.pcfg = SMS_PCFG_STD;                            // R01
    end else begin
      d.pcfg = SMS_PCFG_STORED;                         // R01
    end
    d.mismatch = (!d.periph_sw && eff_dev == SMS_DEV_OTHER) ||
      (d.periph_sw && eff_dev == SMS_DEV_TERM);         // R06
  end
  // startup mode from the selector byte
  always_comb begin
    d.mode = SMS_MODE_PROG;
    case (sel)
      `SMS_SEL_SWITCH: begin                            // R03
        if (d.mismatch) begin
          d.mode = SMS_MODE_PROG;                       // R06
        end else if (d.periph_sw) begin
          d.mode = SMS_MODE_RUN;                        // R04 R09
        end else if (eff_dev == SMS_DEV_TERM) begin
          d.mode = d.key_mode;                          // R05
        end else begin
          d.mode = SMS_MODE_PROG;                       // R09
        end
      end
      `SMS_SEL_LAST: begin
        d.mode = d.last_mode;                           // R03
      end
      `SMS_SEL_WORD: begin                              // R03
        case (low)
          `SMS_LOW_MON: d.mode = SMS_MODE_MON;
          `SMS_LOW_RUN: d.mode = SMS_MODE_RUN;
          default: d.mode = SMS_MODE_PROG;
        endcase
      end
      default: d.mode = SMS_MODE_PROG;                  // undefined: safe
    endcase
  end
endmodule // sms_decide

// ==== rtl/sms_top.sv ====
// startup mode and port select: wishbone registers plus one-shot decision
// assumes synchronous pins, one clock, software starts the decision once
//
// Added by the designer: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "sms_consts.svh"
module sms_top
  import sms_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // front panel and port status
  input wire logic port_settings_switch_i,
  input wire logic peripheral_device_switch_i,
  input wire logic [1:0] periph_dev_i,
  input wire logic [1:0] key_mode_i,
  input wire logic [1:0] last_mode_i,
  // decision results
  output logic [1:0] mode_o,
  output logic mode_valid_o,
  output logic [1:0] periph_cfg_o,
  output logic ser_std_o,
  output logic periph_comm_en_o
);
  typedef struct packed {
    sms_state_t state;
    logic [15:0] setting;
    logic auto_en;
    sms_mode_t mode;
    logic valid;
    sms_pcfg_t pcfg;
    logic ser_std;
    logic comm_en;
    logic mismatch;
    logic ack;
    logic [31:0] dat;
  } sms_regs_t;

  sms_regs_t r_reg;
  sms_regs_t r_next;
  sms_if dif ();
  logic req;
  logic wr;
  logic start;

  // decision inputs come from pins and the setting and control registers
  assign dif.setting = r_reg.setting;
  assign dif.port_sw = port_settings_switch_i;
  assign dif.periph_sw = peripheral_device_switch_i;
  assign dif.auto_en = r_reg.auto_en;
  assign dif.dev = sms_dev_t'(periph_dev_i);
  assign dif.key_mode = sms_mode_t'(key_mode_i);
  assign dif.last_mode = sms_mode_t'(last_mode_i);

  sms_decide u_dec (
    .d(dif.dec)
  );

  // bus request decode: a request is taken while ack is low, and a write
  // lands at the edge that sees ack high, where the master still holds it
  assign req = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && r_reg.ack;
  assign start = wr && wb_adr_i == `SMS_OFF_CTRL && wb_sel_i[0] &&
    wb_dat_i[`SMS_CTRL_START];

  // next state: bus slave, registers and sequencer
  always_comb begin
    r_next = r_reg;
    r_next.ack = req;
    r_next.dat = 32'h0000_0000;
    if (wr && wb_adr_i == `SMS_OFF_SETTING) begin
      if (wb_sel_i[0]) begin
        r_next.setting[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        r_next.setting[15:8] = wb_dat_i[15:8];
      end
    end
    if (wr && wb_adr_i == `SMS_OFF_CTRL && wb_sel_i[0]) begin
      r_next.auto_en = wb_dat_i[`SMS_CTRL_AUTO];        // R08
    end
    if (req && !wb_we_i) begin
      case (wb_adr_i)
        `SMS_OFF_SETTING: r_next.dat = {16'h0000, r_reg.setting};
        `SMS_OFF_CTRL: r_next.dat = {30'h0, r_reg.auto_en, 1'b0};
        `SMS_OFF_STATUS: r_next.dat = {24'h0, r_reg.mismatch,
          r_reg.comm_en, r_reg.ser_std, r_reg.pcfg, r_reg.valid,
          r_reg.mode};
        default: r_next.dat = 32'h0000_0000;
      endcase
    end
    // evaluated once: later start writes are ignored
    case (r_reg.state)
      SMS_ST_IDLE: begin
        if (start) begin
          r_next.state = SMS_ST_LATCH;
        end
      end
      SMS_ST_LATCH: begin
        r_next.mode = dif.mode;                         // R03
        r_next.pcfg = dif.pcfg;                         // R01
        r_next.ser_std = dif.ser_std;                   // R02
        r_next.mismatch = dif.mismatch;
        r_next.comm_en = !dif.mismatch;                 // R06
        r_next.valid = 1'b1;
        r_next.state = SMS_ST_DONE;
      end
      SMS_ST_DONE: r_next.state = SMS_ST_DONE;
      default: r_next.state = SMS_ST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg <= '{state: SMS_ST_IDLE, setting: `SMS_SETTING_RST, // R07
        auto_en: `SMS_AUTO_RST, mode: SMS_MODE_PROG, valid: 1'b0,
        pcfg: SMS_PCFG_TERM, ser_std: 1'b0, comm_en: 1'b0,
        mismatch: 1'b0, ack: 1'b0, dat: 32'h0000_0000};
    end else begin
      r_reg <= r_next;
    end
  end

  // outputs straight from the state register
  assign wb_dat_o = r_reg.dat;
  assign wb_ack_o = r_reg.ack;
  assign mode_o = r_reg.mode;
  assign mode_valid_o = r_reg.valid;
  assign periph_cfg_o = r_reg.pcfg;
  assign ser_std_o = r_reg.ser_std;
  assign periph_comm_en_o = r_reg.comm_en;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic in_latch;
  logic [7:0] sel_now;
  assign in_latch = r_reg.state == SMS_ST_LATCH;
  assign sel_now = r_reg.setting[`SMS_SEL_HI:`SMS_SEL_LO];

  sequence s_start;
    start && r_reg.state == SMS_ST_IDLE;
  endsequence
  sequence s_latched;
    ##1 in_latch ##1 mode_valid_o;
  endsequence

  AST_START_TO_VALID: assert property (s_start |-> s_latched) // R03
    else $error("mode not valid two cycles after start");
  AST_SEL_SWITCH_RUN: assert property ( // R04
    in_latch && sel_now == 8'h00 && peripheral_device_switch_i &&
    periph_dev_i != 2'h1 |=> mode_o == SMS_MODE_RUN)
    else $error("switch on did not start in run mode");
  AST_TERM_KEY: assert property ( // R05
    in_latch && sel_now == 8'h00 && r_reg.auto_en &&
    !peripheral_device_switch_i && periph_dev_i == 2'h1 |=>
    mode_o == $past(key_mode_i))
    else $error("key switch mode not taken");
  AST_MISMATCH_PROG: assert property ( // R06
    in_latch && sel_now == 8'h00 && r_reg.auto_en &&
    peripheral_device_switch_i && periph_dev_i == 2'h1 |=>
    mode_o == SMS_MODE_PROG && !periph_comm_en_o)
    else $error("mismatch did not force program mode");
  // other device with the switch set for a terminal is a mismatch too
  AST_OTHER_PROG: assert property ( // R06
    in_latch && sel_now == 8'h00 && r_reg.auto_en &&
    !peripheral_device_switch_i && periph_dev_i == 2'h2 |=>
    mode_o == SMS_MODE_PROG && !periph_comm_en_o)
    else $error("other device did not force program mode");
  AST_NONE_PROG: assert property ( // R09
    in_latch && sel_now == 8'h00 && r_reg.auto_en &&
    !peripheral_device_switch_i && periph_dev_i == 2'h0 |=>
    mode_o == SMS_MODE_PROG)
    else $error("nothing attached did not give program mode");
  AST_NONE_RUN: assert property ( // R09
    in_latch && sel_now == 8'h00 && r_reg.auto_en &&
    peripheral_device_switch_i && periph_dev_i == 2'h0 |=>
    mode_o == SMS_MODE_RUN && periph_comm_en_o)
    else $error("nothing attached with switch on did not give run");
  AST_LAST_MODE: assert property ( // R03
    in_latch && sel_now == 8'h01 |=> mode_o == $past(last_mode_i))
    else $error("last mode not restored");
  AST_WORD_MON: assert property ( // R03
    in_latch && sel_now == 8'h02 && r_reg.setting[7:0] == 8'h01 |=>
    mode_o == SMS_MODE_MON)
    else $error("lower byte monitor mode not taken");
  AST_SER_STD: assert property ( // R02
    in_latch |=> ser_std_o == $past(port_settings_switch_i))
    else $error("serial port configuration wrong");
  // peripheral port configuration, one check per port configuration
  AST_PCFG_TERM: assert property ( // R01
    in_latch && !peripheral_device_switch_i |=>
    periph_cfg_o == SMS_PCFG_TERM)
    else $error("peripheral port not set for terminal");
  AST_PCFG_STD: assert property ( // R01
    in_latch && peripheral_device_switch_i && port_settings_switch_i |=>
    periph_cfg_o == SMS_PCFG_STD)
    else $error("peripheral port not on standard settings");
  AST_PCFG_STORED: assert property ( // R01
    in_latch && peripheral_device_switch_i && !port_settings_switch_i |=>
    periph_cfg_o == SMS_PCFG_STORED)
    else $error("peripheral port not on stored settings");
  // reset clears the selector and every result
  AST_SEL_RESET: assert property ( // R07
    $fell(rst_i) |-> sel_now == 8'h00)
    else $error("selector byte not zero after reset");
  AST_RESET_OUT: assert property ( // R07
    $fell(rst_i) |-> !mode_valid_o && mode_o == SMS_MODE_PROG &&
    !periph_comm_en_o && !ser_std_o && periph_cfg_o == SMS_PCFG_TERM)
    else $error("results not cleared after reset");
  AST_AUTO_OFF: assert property ( // R08
    in_latch && sel_now == 8'h00 && !r_reg.auto_en &&
    !peripheral_device_switch_i |=> mode_o == $past(key_mode_i))
    else $error("switch not used as detection without auto detect");
  // bus slave answers the cycle after a request, for one cycle only
  AST_ACK_NEXT: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack the cycle after a request");
  AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  AST_ONCE: assert property (mode_valid_o |=> $stable(mode_o))
    else $error("mode changed after decision");
endmodule // sms_top

// ==== tb/sms_periph_model.sv ====
// peripheral port partner: reports the attached device and its key switch
// assumes the bench picks the device kind and the key position
`timescale 1ns/1ps
module sms_periph_model (
  // clock
  input wire logic clk_i,
  // bench choice
  input wire logic [1:0] kind_i,
  input wire logic [1:0] key_i,
  // lines towards the block
  output logic [1:0] dev_o,
  output logic [1:0] key_o
);
  logic [1:0] junk_reg = 2'h0;
  // no terminal means floating key lines: show a changing pattern
  always_ff @(posedge clk_i) begin
    junk_reg <= junk_reg + 2'h1;
  end
  // key lines carry meaning only with a terminal attached
  assign dev_o = kind_i;
  assign key_o = (kind_i == 2'h1) ? key_i : junk_reg;
endmodule // sms_periph_model

// ==== tb/tb_top.sv ====
// self-checking bench of the startup mode and port select block
// assumes a 200 MHz clock and a one-shot decision per reset
`timescale 1ns/1ps
module tb_top;
  import sms_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h3;
  logic [31:0] wdat = 32'h0, rdat;
  logic ack, ssw = 1'b0, psw = 1'b0, valid, ser_std, comm_en;
  logic [1:0] kind = 2'h0, key = 2'h0, last = 2'h1, dev, keyl, mode, pcfg;
  int failures = 0, samples_checked = 0;

  sms_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_settings_switch_i(ssw), .peripheral_device_switch_i(psw),
    .periph_dev_i(dev), .key_mode_i(keyl), .last_mode_i(last),
    .mode_o(mode), .mode_valid_o(valid), .periph_cfg_o(pcfg),
    .ser_std_o(ser_std), .periph_comm_en_o(comm_en));
  sms_periph_model peer (.clk_i(clk_i), .kind_i(kind), .key_i(key),
    .dev_o(dev), .key_o(keyl));

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  // reset values, lane masking and an unmapped address
  task automatic regs();
    logic [31:0] q;
    do_reset();
    chk(32'({valid, mode}), 32'h0);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b0, 4'h4, 32'h0, q);
    chk(q, 32'h2);
    wb(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0);
    wb(1'b1, 4'h0, 32'hFFFF_A5C3, q);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0000_A5C3);
    sel <= 4'h2;
    wb(1'b1, 4'h0, 32'h0000_1234, q);
    sel <= 4'h3;
    wb(1'b1, 4'hC, 32'hFFFF_FFFF, q);
    wb(1'b0, 4'h0, 32'h0, q);
    chk(q, 32'h0000_12C3);
  endtask

  // one power-up decision, then a refused second start
  task automatic scen(input logic p, input logic s, input logic [1:0] k,
    input logic [1:0] km, input logic au, input logic [15:0] set);
    logic [31:0] q;
    logic [1:0] ed, em, ec;
    logic mm;
    int n;
    do_reset();
    chk(32'({comm_en, ser_std, pcfg, valid, mode}), 32'h0);
    psw <= p;
    ssw <= s;
    kind <= k;
    key <= km;
    ed = au ? k : (p ? 2'h2 : 2'h1);
    mm = p ? (ed == 2'h1) : (ed == 2'h2);
    ec = !p ? 2'h0 : (s ? 2'h2 : 2'h1);
    case (set[15:8])
      8'h00: em = p ? (mm ? 2'h0 : 2'h2) : (ed == 2'h1 ? km : 2'h0);
      8'h01: em = last;
      8'h02: em = (set[7:0] < 8'h03) ? set[1:0] : 2'h0;
      default: em = 2'h0;
    endcase
    wb(1'b1, 4'h0, {16'h0, set}, q);
    wb(1'b1, 4'h4, {30'h0, au, 1'b1}, q);
    n = 0;
    while (valid !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(valid), 32'h1);
    chk(32'(mode), 32'(em));
    chk(32'(pcfg), 32'(ec));
    chk(32'(ser_std), 32'(s));
    chk(32'(comm_en), 32'(!mm));
    wb(1'b0, 4'h8, 32'h0, q);
    chk(q, {24'h0, mm, !mm, s, ec, 1'b1, em});
    wb(1'b1, 4'h0, 32'h0000_0202, q);
    wb(1'b1, 4'h4, 32'h3, q);
    repeat (3) @(posedge clk_i);
    chk(32'(mode), 32'(em));
  endtask

  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    regs();
    for (int p = 0; p < 2; p++)
      for (int k = 0; k < 3; k++)
        scen(p[0], k[0], k[1:0], 2'h2, 1'b1, 16'h0000);
    for (int m = 0; m < 3; m++)
      scen(1'b0, 1'b1, 2'h1, m[1:0], 1'b1, 16'h0000);
    scen(1'b0, 1'b0, 2'h1, 2'h1, 1'b0, 16'h0000);
    scen(1'b1, 1'b0, 2'h1, 2'h0, 1'b0, 16'h0000);
    scen(1'b1, 1'b0, 2'h1, 2'h0, 1'b1, 16'h0100);
    for (int m = 0; m < 4; m++)
      scen(1'b1, 1'b1, 2'h2, 2'h0, 1'b1, {8'h02, 8'(m)});
    scen(1'b0, 1'b0, 2'h0, 2'h0, 1'b1, 16'h0502);
    conclude();
  end

  // watchdog against a hang
  initial begin
    #50000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    conclude();
  end
endmodule // tb_top
